// ==== hdl/gft_regs.v ====
// gci format, line threshold interrupt and echo tap register slice
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "gft_defines.vh"
module gft_regs #(
	parameter AW = 12
) (
	input  wire          sys_clk_in,
	input  wire          srst_in,
	input  wire          psel_in,
	input  wire          penable_in,
	input  wire          pwrite_in,
	input  wire [AW-1:0] paddr_in,
	input  wire [31:0]   pwdata_in,
	output reg  [31:0]   prdata_out,
	output wire          pready_out,
	output wire          pslverr_out,
	input  wire [7:0]    loop_current_reading_in,
	input  wire          loop_current_valid_in,
	input  wire [7:0]    line_voltage_reading_in,
	input  wire          line_voltage_valid_in,
	input  wire [15:0]   line_tx_sample_in,
	input  wire          line_tx_valid_in,
	output reg  [7:0]    b1_tx_byte_out,
	output reg           b1_tx_valid_out,
	output reg  [7:0]    b2_tx_byte_out,
	output reg           b2_tx_valid_out,
	input  wire [7:0]    b1_rx_byte_in,
	input  wire [7:0]    b2_rx_byte_in,
	input  wire          rx_frame_valid_in,
	output reg  [15:0]   line_rx_sample_out,
	output reg           line_rx_valid_out,
	output reg  [15:0]   echo_tap_term_out,
	output reg           echo_tap_valid_out,
	output reg           aux_out_irq_pin_out
);

	reg  [1:0]  gci_sample_format_r;
	reg         second_bearer_enable_r;
	reg         first_bearer_enable_r;
	reg  [7:0]  line_threshold_value_r;
	reg         threshold_crossed_flag_r;
	reg         threshold_source_select_r;
	reg         threshold_irq_mask_r;
	reg         threshold_direction_r;
	reg  [7:0]  echo_tap_one_coeff_r;
	reg         global_irq_enable_r;
	reg  [`GFT_IRQ_W-1:0] irq_status_r;
	reg  [`GFT_IRQ_W-1:0] irq_mask_r;
	reg  [7:0]  last_abs_r;
	reg         last_hit_r;

	reg  [`GFT_IRQ_W-1:0] irq_status_nxt;
	reg         flag_nxt;
	reg  [31:0] rdata_nxt;
	reg         addr_hit;
	reg  [7:0]  b1_tx_nxt;
	reg  [7:0]  b2_tx_nxt;
	reg         b1_tx_vld_nxt;
	reg         b2_tx_vld_nxt;
	reg  [15:0] rx_nxt;
	reg         rx_vld_nxt;
	reg         tx_drop;
	reg         rx_drop;

	wire [7:0]  word_idx;
	wire        aligned;
	wire        wr_en;
	wire        rd_setup;
	wire [7:0]  sel_reading;
	wire        sel_valid;
	wire [7:0]  sel_abs;
	wire        sel_hit;
	wire        thr_event;
	wire [7:0]  enc_code;
	wire [15:0] dec_sample;
	wire        fmt_mu;
	wire [7:0]  dec_src;
	wire signed [23:0] echo_prod;

	// zero wait states keep the bus simple; data is staged at setup
	assign pready_out = 1'b1;
	assign word_idx   = paddr_in[9:2];
	assign aligned    = (paddr_in[1:0] == 2'b00) &&
	                    (paddr_in[AW-1:10] == {(AW-10){1'b0}});
	assign wr_en      = psel_in & penable_in & pwrite_in & addr_hit;
	assign rd_setup   = psel_in & ~penable_in & ~pwrite_in;
	assign pslverr_out = psel_in & penable_in & ~addr_hit;

	always @* begin
		addr_hit = 1'b0;
		if (!aligned)
			addr_hit = 1'b0;
		else if (word_idx == `GFT_IDX_GCI_CTRL)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_THR_VALUE)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_THR_CTRL)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_ECHO_TAP1)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_GLOBAL_CTRL)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_IRQ_STATUS)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_IRQ_MASK)
			addr_hit = 1'b1;
		else if (word_idx == `GFT_IDX_LINE_STATUS)
			addr_hit = 1'b1;
	end

	// read mux; reserved bits come back as zero
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (!aligned)
			rdata_nxt = 32'h0000_0000;
		else if (word_idx == `GFT_IDX_GCI_CTRL)
			rdata_nxt[3:0] = {gci_sample_format_r, second_bearer_enable_r,
			                  first_bearer_enable_r};
		else if (word_idx == `GFT_IDX_THR_VALUE)
			rdata_nxt[7:0] = line_threshold_value_r;
		else if (word_idx == `GFT_IDX_THR_CTRL)
			rdata_nxt[3:0] = {threshold_crossed_flag_r,
			                  threshold_source_select_r,
			                  threshold_irq_mask_r, threshold_direction_r};
		else if (word_idx == `GFT_IDX_ECHO_TAP1)
			rdata_nxt[7:0] = echo_tap_one_coeff_r;
		else if (word_idx == `GFT_IDX_GLOBAL_CTRL)
			rdata_nxt[0] = global_irq_enable_r;
		else if (word_idx == `GFT_IDX_IRQ_STATUS)
			rdata_nxt[`GFT_IRQ_W-1:0] = irq_status_r;
		else if (word_idx == `GFT_IDX_IRQ_MASK)
			rdata_nxt[`GFT_IRQ_W-1:0] = irq_mask_r;
		else if (word_idx == `GFT_IDX_LINE_STATUS)
			rdata_nxt[8:0] = {last_hit_r, last_abs_r};
	end

	always @(posedge sys_clk_in) begin
		if (srst_in)
			prdata_out <= 32'h0000_0000;
		else if (rd_setup)
			prdata_out <= rdata_nxt;
	end

	// configuration registers
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			gci_sample_format_r       <= 2'b00;
			second_bearer_enable_r    <= 1'b0;
			first_bearer_enable_r     <= 1'b0;
			line_threshold_value_r    <= `GFT_RST_BYTE;
			threshold_source_select_r <= 1'b0;
			threshold_irq_mask_r      <= 1'b0;
			threshold_direction_r     <= 1'b0;
			echo_tap_one_coeff_r      <= `GFT_RST_BYTE;
			global_irq_enable_r       <= 1'b0;
			irq_mask_r                <= `GFT_RST_IRQ;
		end else if (wr_en) begin
			if (word_idx == `GFT_IDX_GCI_CTRL) begin
				gci_sample_format_r <=
					pwdata_in[`GFT_GCI_FMT_MSB:`GFT_GCI_FMT_LSB];
				second_bearer_enable_r <= pwdata_in[`GFT_GCI_B2_BIT];
				first_bearer_enable_r  <= pwdata_in[`GFT_GCI_B1_BIT];
			end else if (word_idx == `GFT_IDX_THR_VALUE) begin
				line_threshold_value_r <= pwdata_in[7:0];
			end else if (word_idx == `GFT_IDX_THR_CTRL) begin
				threshold_source_select_r <= pwdata_in[`GFT_THR_SRC_BIT];
				threshold_irq_mask_r      <= pwdata_in[`GFT_THR_MASK_BIT];
				threshold_direction_r     <= pwdata_in[`GFT_THR_DIR_BIT];
			end else if (word_idx == `GFT_IDX_ECHO_TAP1) begin
				echo_tap_one_coeff_r <= pwdata_in[7:0];
			end else if (word_idx == `GFT_IDX_GLOBAL_CTRL) begin
				global_irq_enable_r <= pwdata_in[`GFT_GLB_IRQ_EN_BIT];
			end else if (word_idx == `GFT_IDX_IRQ_MASK) begin
				irq_mask_r <= pwdata_in[`GFT_IRQ_W-1:0];
			end
		end
	end

	// measurement selection and comparison
	assign sel_reading = threshold_source_select_r ?
	                     line_voltage_reading_in :
	                     loop_current_reading_in;
	assign sel_valid   = threshold_source_select_r ?
	                     line_voltage_valid_in :
	                     loop_current_valid_in;

	gft_thresh #(
		.W (8)
	) u_thresh (
		.reading_in (sel_reading),
		.thr_in     (line_threshold_value_r),
		.above_in   (threshold_direction_r),
		.abs_out    (sel_abs),
		.hit_out    (sel_hit)
	);

	assign thr_event = sel_valid & sel_hit;

	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			last_abs_r <= 8'h00;
			last_hit_r <= 1'b0;
		end else if (sel_valid) begin
			last_abs_r <= sel_abs;
			last_hit_r <= sel_hit;
		end
	end

	// flag is cleared by writing zero; a same-cycle crossing wins
	always @* begin
		flag_nxt = threshold_crossed_flag_r;
		if (wr_en && word_idx == `GFT_IDX_THR_CTRL &&
		    !pwdata_in[`GFT_THR_FLAG_BIT])
			flag_nxt = 1'b0;
		if (thr_event)
			flag_nxt = 1'b1;
	end

	always @* begin
		irq_status_nxt = irq_status_r;
		if (wr_en && word_idx == `GFT_IDX_IRQ_STATUS)
			irq_status_nxt = irq_status_r & ~pwdata_in[`GFT_IRQ_W-1:0];
		if (thr_event)
			irq_status_nxt[`GFT_IRQ_THR_BIT] = 1'b1;
		if (tx_drop)
			irq_status_nxt[`GFT_IRQ_TXDROP_BIT] = 1'b1;
		if (rx_drop)
			irq_status_nxt[`GFT_IRQ_RXDROP_BIT] = 1'b1;
	end

	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			threshold_crossed_flag_r <= 1'b0;
			irq_status_r             <= `GFT_RST_IRQ;
			aux_out_irq_pin_out      <= 1'b0;
		end else begin
			threshold_crossed_flag_r <= flag_nxt;
			irq_status_r             <= irq_status_nxt;
			aux_out_irq_pin_out      <= global_irq_enable_r &
				((flag_nxt & threshold_irq_mask_r) |
				 (|(irq_status_nxt & irq_mask_r)));
		end
	end

	// sample path; one companding unit serves both directions
	assign fmt_mu  = (gci_sample_format_r == `GFT_FMT_MULAW);
	assign dec_src = first_bearer_enable_r ? b1_rx_byte_in : b2_rx_byte_in;

	gft_compand u_compand (
		.mu_law_in      (fmt_mu),
		.enc_sample_in  (line_tx_sample_in),
		.enc_code_out   (enc_code),
		.dec_code_in    (dec_src),
		.dec_sample_out (dec_sample)
	);

	always @* begin
		b1_tx_nxt     = 8'h00;
		b2_tx_nxt     = 8'h00;
		b1_tx_vld_nxt = 1'b0;
		b2_tx_vld_nxt = 1'b0;
		tx_drop       = 1'b0;
		case (gci_sample_format_r)
		`GFT_FMT_ALAW, `GFT_FMT_MULAW: begin
			b1_tx_nxt = enc_code;
			b2_tx_nxt = enc_code;
		end
		`GFT_FMT_LIN8: begin
			b1_tx_nxt = line_tx_sample_in[15:8];
			b2_tx_nxt = line_tx_sample_in[15:8];
		end
		default: begin
			b1_tx_nxt = line_tx_sample_in[15:8];
			b2_tx_nxt = line_tx_sample_in[7:0];
		end
		endcase
		if (line_tx_valid_in) begin
			b1_tx_vld_nxt = first_bearer_enable_r;
			b2_tx_vld_nxt = second_bearer_enable_r;
			tx_drop = ~first_bearer_enable_r & ~second_bearer_enable_r;
		end
	end

	always @* begin
		rx_nxt     = 16'h0000;
		rx_vld_nxt = 1'b0;
		rx_drop    = 1'b0;
		case (gci_sample_format_r)
		`GFT_FMT_ALAW, `GFT_FMT_MULAW:
			rx_nxt = dec_sample;
		`GFT_FMT_LIN8:
			rx_nxt = {dec_src, 8'h00};
		default: begin
			if (first_bearer_enable_r && second_bearer_enable_r)
				rx_nxt = {b1_rx_byte_in, b2_rx_byte_in};
			else if (first_bearer_enable_r)
				rx_nxt = {b1_rx_byte_in, 8'h00};
			else
				rx_nxt = {8'h00, b2_rx_byte_in};
		end
		endcase
		if (rx_frame_valid_in) begin
			rx_vld_nxt = first_bearer_enable_r | second_bearer_enable_r;
			rx_drop    = ~rx_vld_nxt;
		end
	end

	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			b1_tx_byte_out     <= 8'h00;
			b2_tx_byte_out     <= 8'h00;
			b1_tx_valid_out    <= 1'b0;
			b2_tx_valid_out    <= 1'b0;
			line_rx_sample_out <= 16'h0000;
			line_rx_valid_out  <= 1'b0;
		end else begin
			b1_tx_valid_out   <= b1_tx_vld_nxt;
			b2_tx_valid_out   <= b2_tx_vld_nxt;
			line_rx_valid_out <= rx_vld_nxt;
			if (b1_tx_vld_nxt)
				b1_tx_byte_out <= b1_tx_nxt;
			if (b2_tx_vld_nxt)
				b2_tx_byte_out <= b2_tx_nxt;
			if (rx_vld_nxt)
				line_rx_sample_out <= rx_nxt;
		end
	end

	// first echo tap: sample times signed q1.7 coefficient
	assign echo_prod = $signed(line_tx_sample_in) *
	                   $signed(echo_tap_one_coeff_r);

	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			echo_tap_term_out  <= 16'h0000;
			echo_tap_valid_out <= 1'b0;
		end else begin
			echo_tap_valid_out <= line_tx_valid_in;
			if (line_tx_valid_in)
				echo_tap_term_out <= echo_prod[22:7];
		end
	end

endmodule

// ==== hdl/gft_defines.vh ====
// register indices, field positions and reset values for the gci block
`ifndef GFT_DEFINES_VH
`define GFT_DEFINES_VH

`define GFT_IDX_GCI_CTRL     8'h2a
`define GFT_IDX_THR_VALUE    8'h2b
`define GFT_IDX_THR_CTRL     8'h2c
`define GFT_IDX_ECHO_TAP1    8'h2d
`define GFT_IDX_GLOBAL_CTRL  8'h30
`define GFT_IDX_IRQ_STATUS   8'h31
`define GFT_IDX_IRQ_MASK     8'h32
`define GFT_IDX_LINE_STATUS  8'h33

`define GFT_GCI_B1_BIT       0
`define GFT_GCI_B2_BIT       1
`define GFT_GCI_FMT_LSB      2
`define GFT_GCI_FMT_MSB      3

`define GFT_THR_DIR_BIT      0
`define GFT_THR_MASK_BIT     1
`define GFT_THR_SRC_BIT      2
`define GFT_THR_FLAG_BIT     3

`define GFT_FMT_ALAW         2'b00
`define GFT_FMT_MULAW        2'b01
`define GFT_FMT_LIN8         2'b10
`define GFT_FMT_LIN16        2'b11

`define GFT_IRQ_THR_BIT      0
`define GFT_IRQ_TXDROP_BIT   1
`define GFT_IRQ_RXDROP_BIT   2
`define GFT_IRQ_W            3

`define GFT_GLB_IRQ_EN_BIT   0

`define GFT_RST_BYTE         8'h00
`define GFT_RST_IRQ          3'h0

`endif

// ==== hdl/gft_compand.v ====
// g.711 a-law and mu-law encoder and decoder, purely combinational
`timescale 1ns/1ps
module gft_compand (
	input  wire        mu_law_in,
	input  wire [15:0] enc_sample_in,
	output reg  [7:0]  enc_code_out,
	input  wire [7:0]  dec_code_in,
	output reg  [15:0] dec_sample_out
);

	integer     i;
	reg         neg;
	reg  [15:0] mag;
	reg  [13:0] v;
	reg  [12:0] m12;
	reg  [2:0]  seg;
	reg  [15:0] sh;
	reg  [7:0]  u;
	reg  [15:0] t;

	always @* begin
		neg = enc_sample_in[15];
		mag = neg ? (16'h0000 - enc_sample_in) : enc_sample_in;
		v   = 14'h0000;
		m12 = 13'h0000;
		seg = 3'h0;
		sh  = 16'h0000;
		if (mu_law_in) begin
			v = (mag[15:2] > 14'h1fde) ? 14'h1fde : mag[15:2];
			v = v + 14'h0021;
			for (i = 5; i <= 12; i = i + 1) begin
				if (v[i])
					seg = i[2:0] - 3'h5;
			end
			sh = {2'b00, v} >> ({1'b0, seg} + 4'h1);
			enc_code_out = {~neg, ~seg, ~sh[3:0]};
		end else begin
			m12 = (mag[15:3] > 13'h0fff) ? 13'h0fff : mag[15:3];
			for (i = 5; i <= 11; i = i + 1) begin
				if (m12[i])
					seg = i[2:0] - 3'h4;
			end
			sh = (seg == 3'h0) ? {3'b000, m12} >> 1 : {3'b000, m12} >> seg;
			enc_code_out = {~neg, seg, sh[3:0]} ^ 8'h55;
		end
	end

	// decoders return full 16-bit scale, so no further shift is needed
	always @* begin
		u = 8'h00;
		t = 16'h0000;
		if (mu_law_in) begin
			u = ~dec_code_in;
			t = ({9'h000, u[3:0], 3'b000} + 16'h0084) << u[6:4];
			t = t - 16'h0084;
			dec_sample_out = u[7] ? (16'h0000 - t) : t;
		end else begin
			u = dec_code_in ^ 8'h55;
			t = {8'h00, u[3:0], 4'h0};
			if (u[6:4] == 3'h0)
				t = t + 16'h0008;
			else
				t = (t + 16'h0108) << (u[6:4] - 3'h1);
			dec_sample_out = u[7] ? t : (16'h0000 - t);
		end
	end

endmodule

// ==== hdl/gft_thresh.v ====
// absolute value of a signed reading compared against a threshold
`timescale 1ns/1ps
module gft_thresh #(
	parameter W = 8
) (
	input  wire [W-1:0] reading_in,
	input  wire [W-1:0] thr_in,
	input  wire         above_in,
	output wire [W-1:0] abs_out,
	output wire         hit_out
);

	// most negative code maps to its true magnitude as unsigned
	assign abs_out = reading_in[W-1] ? ({W{1'b0}} - reading_in) : reading_in;
	assign hit_out = above_in ? (abs_out > thr_in) : (abs_out < thr_in);

endmodule

// ==== tb/gft_regs_sva.sv ====
// checker for the gci format and threshold register slice
`timescale 1ns/1ps
module gft_regs_chk #(
	parameter AW = 12
) (
	input logic          sys_clk_in,
	input logic          srst_in,
	input logic          psel_in,
	input logic          penable_in,
	input logic          pwrite_in,
	input logic [AW-1:0] paddr_in,
	input logic [31:0]   prdata_out,
	input logic          pready_out,
	input logic          pslverr_out,
	input logic          loop_current_valid_in,
	input logic          line_voltage_valid_in,
	input logic          line_tx_valid_in,
	input logic          rx_frame_valid_in,
	input logic          b1_tx_valid_out,
	input logic          b2_tx_valid_out,
	input logic          line_rx_valid_out,
	input logic          echo_tap_valid_out,
	input logic          aux_out_irq_pin_out
);
	wire acc = psel_in && penable_in;
	wire mapped = paddr_in[1:0] == 2'h0 &&
		((paddr_in >= 'h0a8 && paddr_in <= 'h0b4) ||
		(paddr_in >= 'h0c0 && paddr_in <= 'h0cc));
	// mask and enable come from registers, so a write lifts the pin late
	logic wr_d = 1'b0;
	always @(posedge sys_clk_in) wr_d <= acc && pwrite_in;
	// any of these may legally raise the pin
	wire ev = loop_current_valid_in || line_voltage_valid_in ||
		wr_d || line_tx_valid_in || rx_frame_valid_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	a_ready_high: assert property (acc |-> pready_out)
		else $error("pready low in access");
	a_err_map: assert property (acc |-> pslverr_out == !mapped)
		else $error("pslverr wrong for address");
	a_rd_err_zero: assert property (acc && !pwrite_in && !mapped
		|-> prdata_out == 32'h0) else $error("unmapped read not zero");
	a_b1_cause: assert property (b1_tx_valid_out
		|-> $past(line_tx_valid_in)) else $error("b1 pulse uncaused");
	a_b2_cause: assert property (b2_tx_valid_out
		|-> $past(line_tx_valid_in)) else $error("b2 pulse uncaused");
	a_echo_pulse: assert property (echo_tap_valid_out ==
		$past(line_tx_valid_in)) else $error("echo pulse mistimed");
	a_rx_cause: assert property (line_rx_valid_out
		|-> $past(rx_frame_valid_in)) else $error("rx pulse uncaused");
	a_irq_cause: assert property ($rose(aux_out_irq_pin_out)
		|-> $past(ev)) else $error("irq rose without event");
	// reset itself is the cause here, so no disable
	a_reset_quiet: assert property (disable iff (1'b0) srst_in
		|=> !aux_out_irq_pin_out && !b1_tx_valid_out && !b2_tx_valid_out
		&& !line_rx_valid_out) else $error("outputs busy after reset");
endmodule
bind gft_regs gft_regs_chk #(.AW(AW)) u_chk (
	.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out),
	.loop_current_valid_in(loop_current_valid_in),
	.line_voltage_valid_in(line_voltage_valid_in),
	.line_tx_valid_in(line_tx_valid_in),
	.rx_frame_valid_in(rx_frame_valid_in),
	.b1_tx_valid_out(b1_tx_valid_out), .b2_tx_valid_out(b2_tx_valid_out),
	.line_rx_valid_out(line_rx_valid_out),
	.echo_tap_valid_out(echo_tap_valid_out),
	.aux_out_irq_pin_out(aux_out_irq_pin_out));

// ==== tb/gft_gci_host.sv ====
// gci host model driving receive frames into the device
`timescale 1ns/1ps
module gft_gci_host (
	input  logic       clk_in,
	input  logic       send_in,
	input  logic [7:0] b1_in,
	input  logic [7:0] b2_in,
	output logic [7:0] b1_rx_out = 8'h00,
	output logic [7:0] b2_rx_out = 8'h00,
	output logic       frame_out = 1'b0
);
	// outside a frame the bytes toggle so stale data never looks valid
	always @(posedge clk_in) begin
		frame_out <= send_in;
		b1_rx_out <= send_in ? b1_in : ~b1_rx_out;
		b2_rx_out <= send_in ? b2_in : ~b2_rx_out;
	end
endmodule

// ==== tb/gft_regs_tb_top.sv ====
// self-checking bench for the gci format and threshold register slice
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	n_errors++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module gft_regs_tb_top;
	logic        sys_clk_in = 0, srst_in = 1;
	logic        psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, cv = 0, vv = 0, tv = 0, send = 0;
	logic [7:0]  cr = 0, vr = 0, b1t, b2t, b1r, b2r, h1 = 0, h2 = 0;
	logic        b1v, b2v, fv, rxv, ev, irq;
	logic [15:0] ts = 0, rxs, echo;
	int          n_errors = 0, compares = 0, cyc = 0, i;
	logic [3:0]  cfg[10] = '{4'h3, 4'h7, 4'h3, 4'h7, 4'hb, 4'h9, 4'ha,
		4'hf, 4'hd, 4'he};
	logic [15:0] smp[10] = '{0, 0, 16'h1234, 16'h1234, 16'h1234,
		16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h1234};
	logic [17:0] ex[10] = '{{1'b1, 8'hd5, 1'b1, 8'hd5},
		{1'b1, 8'hff, 1'b1, 8'hff}, {1'b1, 8'h87, 1'b1, 8'h87},
		{1'b1, 8'had, 1'b1, 8'had}, {1'b1, 8'h12, 1'b1, 8'h12},
		{1'b1, 8'h12, 1'b0, 8'h00}, {1'b0, 8'h00, 1'b1, 8'h12},
		{1'b1, 8'h12, 1'b1, 8'h34}, {1'b1, 8'h12, 1'b0, 8'h00},
		{1'b0, 8'h00, 1'b1, 8'h34}};
	always #20 sys_clk_in = ~sys_clk_in;
	gft_regs DUT (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.loop_current_reading_in(cr), .loop_current_valid_in(cv),
		.line_voltage_reading_in(vr), .line_voltage_valid_in(vv),
		.line_tx_sample_in(ts), .line_tx_valid_in(tv),
		.b1_tx_byte_out(b1t), .b1_tx_valid_out(b1v),
		.b2_tx_byte_out(b2t), .b2_tx_valid_out(b2v),
		.b1_rx_byte_in(b1r), .b2_rx_byte_in(b2r), .rx_frame_valid_in(fv),
		.line_rx_sample_out(rxs), .line_rx_valid_out(rxv),
		.echo_tap_term_out(echo), .echo_tap_valid_out(ev),
		.aux_out_irq_pin_out(irq));
	gft_gci_host u_host (.clk_in(sys_clk_in), .send_in(send), .b1_in(h1),
		.b2_in(h2), .b1_rx_out(b1r), .b2_rx_out(b2r), .frame_out(fv));
	task wrap_up;
		if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1;
		do begin
			@(posedge sys_clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk_in);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		`CHK("reg", e, rd)
	endtask
	task tx(input logic [15:0] s, input logic [17:0] e, input logic [15:0] ee);
		ts <= s;
		tv <= 1;
		@(posedge sys_clk_in);
		tv <= 0;
		@(negedge sys_clk_in);
		`CHK("tx", e, {b1v, b1v ? b1t : 8'h0, b2v, b2v ? b2t : 8'h0})
		`CHK("echo", {1'b1, ee}, {ev, echo})
		@(posedge sys_clk_in);
	endtask
	task rx(input logic [15:0] e);
		h1 <= 8'hab;
		h2 <= 8'hcd;
		send <= 1;
		@(posedge sys_clk_in);
		send <= 0;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK("rx", {1'b1, e}, {rxv, rxs})
		@(posedge sys_clk_in);
	endtask
	// one measurement pulse; the pin is read after the flag settles
	task meas(input logic v, input logic [7:0] x, input logic ei);
		if (v) vr <= x;
		else cr <= x;
		vv <= v;
		cv <= !v;
		@(posedge sys_clk_in);
		vv <= 0;
		cv <= 0;
		@(posedge sys_clk_in);
		`CHK("irq", ei, irq)
	endtask
	initial begin
		repeat (10) @(posedge sys_clk_in);
		srst_in <= 0;
		repeat (2) @(posedge sys_clk_in);
		for (i = 0; i < 4; i++) rdc(12'h0a8 + 4 * i, 0);
		wr(12'h0a8, 32'hffffffff);
		rdc(12'h0a8, 32'h0f);
		wr(12'h0b0, 32'hff);
		rdc(12'h0b0, 32'h07);
		wr(12'h0ac, 32'hff);
		rdc(12'h0ac, 32'hff);
		wr(12'h0b4, 32'ha5);
		rdc(12'h0b4, 32'ha5);
		rdc(12'h0a4, 0);
		`CHK("err", 1'b1, er)
		wr(12'h0b4, 0);
		for (i = 0; i < 10; i++) begin
			wr(12'h0a8, {28'h0, cfg[i]});
			tx(smp[i], ex[i], 0);
		end
		wr(12'h0b4, 32'h40);
		tx(16'h0100, {1'b0, 8'h00, 1'b1, 8'h00}, 16'h0080);
		wr(12'h0a8, 32'h0);
		tx(16'h0100, 18'h0, 16'h0080);
		rdc(12'h0c4, 32'h2);
		wr(12'h0c4, 32'h2);
		wr(12'h0a8, 32'hf);
		rx(16'habcd);
		wr(12'h0a8, 32'he);
		rx(16'h00cd);
		wr(12'h0a8, 32'hd);
		rx(16'hab00);
		wr(12'h0a8, 32'h9);
		rx(16'hab00);
		wr(12'h0a8, 32'h1);
		rx(16'h7a00);
		wr(12'h0a8, 32'h5);
		rx(16'h13fc);
		wr(12'h0c0, 1);
		wr(12'h0ac, 32'h40);
		wr(12'h0b0, 32'h03);
		meas(0, 8'hc0, 0);
		meas(1, 8'h7f, 0);
		rdc(12'h0b0, 32'h03);
		meas(0, 8'hbf, 1);
		rdc(12'h0b0, 32'h0b);
		rdc(12'h0c4, 1);
		wr(12'h0c4, 1);
		rdc(12'h0c4, 0);
		wr(12'h0b0, 32'h03);
		rdc(12'h0b0, 32'h03);
		`CHK("irq", 1'b0, irq)
		wr(12'h0b0, 0);
		meas(0, 8'h10, 0);
		rdc(12'h0b0, 32'h08);
		wr(12'h0b0, 32'h0a);
		@(posedge sys_clk_in);
		`CHK("irq", 1'b1, irq)
		wr(12'h0c0, 0);
		@(posedge sys_clk_in);
		`CHK("irq", 1'b0, irq)
		wr(12'h0b0, 32'h04);
		meas(0, 8'h05, 0);
		rdc(12'h0b0, 32'h04);
		meas(1, 8'h05, 0);
		rdc(12'h0b0, 32'h0c);
		wrap_up;
	end
endmodule
